// *** rtl/hpsc_slot_regs.sv ***
`timescale 1ns/1ps
`include "hpsc_map.svh"

module hpsc_slot_regs (
	input  logic        pclk,                // Core clock, 40 MHz
	input  logic        presetn,             // Async reset, active low
	input  logic        psel,                // APB select
	input  logic        penable,             // APB access phase
	input  logic        pwrite,              // APB direction, high for write
	input  logic [11:0] paddr,               // APB byte address
	input  logic [31:0] pwdata,              // APB write data
	input  logic [3:0]  pstrb,               // APB byte strobes
	output logic [31:0] prdata,              // APB read data
	output logic        pready,              // APB ready
	output logic        pslverr,             // APB error on unmapped address
	input  logic        attn_button,         // Button pin, high while pressed
	input  logic        power_fault_in,      // Power controller fault pin
	input  logic        latch_open_in,       // Retention latch sensor, high when open
	input  logic        card_present_in,     // Presence detect pin
	input  logic        interlock_engaged_in,// Interlock feedback pin
	input  logic        link_active,         // Link active level, same clock
	input  logic        cmd_done,            // Command finished pulse, same clock
	output logic        interlock_toggle,    // One-cycle pulse to flip the interlock
	output logic        hotplug_irq          // Hot-plug interrupt level
);

	// Bus handshake state
	logic        pready_q;
	logic        pslverr_q;
	logic [31:0] prdata_q;

	// Software visible registers
	hpsc_pkg::hpsc_reg16_t sctl_q;
	hpsc_pkg::hpsc_reg16_t sctl_d;
	hpsc_pkg::hpsc_reg16_t cfg_q;
	hpsc_pkg::hpsc_reg16_t cfg_d;
	hpsc_pkg::hpsc_reg16_t mask_q;
	hpsc_pkg::hpsc_reg16_t mask_d;

	// Pin images and previous values for edge detection
	logic [4:0] pin_sync;
	logic       button_prev_q;
	logic       fault_prev_q;
	logic       latch_prev_q;
	logic       card_prev_q;
	logic       link_prev_q;
	logic       toggle_q;
	logic       irq_q;

	// Decode of the current bus request
	hpsc_pkg::hpsc_sel_t   sel;
	wire        acc      = psel & penable;
	wire        first    = acc & ~pready_q;
	wire        done     = acc & pready_q;
	wire        wr_go    = done & pwrite;
	wire [15:0] lane_m   = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	wire        wr_sctl  = wr_go & (sel == hpsc_pkg::HPSC_SEL_SCTL);
	wire        wr_ssts  = wr_go & (sel == hpsc_pkg::HPSC_SEL_SSTS);
	wire        wr_cfg   = wr_go & (sel == hpsc_pkg::HPSC_SEL_CFG);
	wire        wr_mask  = wr_go & (sel == hpsc_pkg::HPSC_SEL_MASK);

	assign sel = (paddr == `HPSC_SCTL_ADDR) ? hpsc_pkg::HPSC_SEL_SCTL :
		     (paddr == `HPSC_SSTS_ADDR) ? hpsc_pkg::HPSC_SEL_SSTS :
		     (paddr == `HPSC_CFG_ADDR)  ? hpsc_pkg::HPSC_SEL_CFG  :
		     (paddr == `HPSC_MASK_ADDR) ? hpsc_pkg::HPSC_SEL_MASK :
		     hpsc_pkg::HPSC_SEL_NONE;

	// Live pin levels after synchronisation
	wire button_s = pin_sync[0];
	wire fault_s  = pin_sync[1];
	wire latch_s  = pin_sync[2];
	wire card_s   = pin_sync[3];
	wire ilock_s  = pin_sync[4];
	wire ilock_ok = cfg_q[`HPSC_CFG_ILOCK];

	hpsc_sync #(
		.WIDTH   (5),
		.RST_VAL (`HPSC_PIN_RST)
	) u_pin_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     ({interlock_engaged_in, card_present_in, latch_open_in,
			 power_fault_in, attn_button}),
		.q     (pin_sync)
	);

	// Slot events; level pins become edges so a held level raises one event
	wire button_rise = button_s & ~button_prev_q;
	wire fault_rise  = fault_s & ~fault_prev_q;
	wire latch_chg   = latch_s ^ latch_prev_q;
	wire card_chg    = card_s ^ card_prev_q;
	wire link_chg    = link_active ^ link_prev_q;

	wire [15:0] ev_set = {7'h00, link_chg, 3'h0, cmd_done, card_chg,
			      latch_chg, fault_rise, button_rise};
	wire [15:0] ev_clr = pwdata[15:0] & lane_m & {16{wr_ssts}};
	wire [15:0] flags;

	// One sticky flag per event bit; other bits stay zero
	genvar gi;
	generate
		for (gi = 0; gi < 16; gi++) begin : g_flag
			if ((`HPSC_SSTS_W1C_MASK & (16'h0001 << gi)) != 16'h0000) begin : g_on
				hpsc_evflag u_flag (
					.clk    (pclk),
					.rst_n  (presetn),
					.set    (ev_set[gi]),
					.clr    (ev_clr[gi]),
					.flag_q (flags[gi])
				);
			end else begin : g_off
				assign flags[gi] = 1'b0;
			end
		end
	endgenerate

	// Status image: sticky flags plus live state, reserved bits zero
	wire        ilock_st = ilock_s & ilock_ok;
	wire [15:0] ssts_rd  = flags | {8'h00, ilock_st, card_s, latch_s, 5'h00};
	// Toggle bit is never stored, so it always reads zero
	wire [15:0] sctl_rd  = sctl_q & `HPSC_SCTL_WMASK;

	wire [31:0] rd_word = (sel == hpsc_pkg::HPSC_SEL_SCTL) ? {16'h0000, sctl_rd} :
			      (sel == hpsc_pkg::HPSC_SEL_SSTS) ? {16'h0000, ssts_rd} :
			      (sel == hpsc_pkg::HPSC_SEL_CFG)  ? {16'h0000, cfg_q}   :
			      (sel == hpsc_pkg::HPSC_SEL_MASK) ? {16'h0000, mask_q}  :
			      32'h0000_0000;

	// Register writes honour byte strobes; reserved bits are never stored
	wire [15:0] sctl_wm = lane_m & {16{wr_sctl}} & `HPSC_SCTL_WMASK;
	wire [15:0] cfg_wm  = lane_m & {16{wr_cfg}} & `HPSC_CFG_WMASK;
	wire [15:0] mask_wm = lane_m & {16{wr_mask}} & `HPSC_SSTS_W1C_MASK;

	assign sctl_d = (sctl_q & ~sctl_wm) | (pwdata[15:0] & sctl_wm);
	assign cfg_d  = (cfg_q & ~cfg_wm) | (pwdata[15:0] & cfg_wm);
	assign mask_d = (mask_q & ~mask_wm) | (pwdata[15:0] & mask_wm);

	// A one in the toggle bit only acts when the interlock exists
	wire toggle_d = wr_sctl & pstrb[1] & pwdata[`HPSC_SCTL_TOGGLE] & ilock_ok;

	// Enables per flag, each gated by the master enable and the mask
	wire [15:0] flag_en = {7'h00, sctl_q[`HPSC_SCTL_DLCE], 3'h0, sctl_q[4:0]};
	wire        irq_d   = sctl_q[`HPSC_SCTL_MASTER] & (|(flags & flag_en & mask_q));

	// Bus slave: one wait state so read data comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= 32'h0000_0000;
		end else begin
			pready_q  <= first;
			pslverr_q <= first & (sel == hpsc_pkg::HPSC_SEL_NONE);
			if (first) begin
				prdata_q <= rd_word;
			end
		end
	end

	// Control, configuration and mask registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sctl_q <= `HPSC_SCTL_RST;
			cfg_q  <= `HPSC_CFG_RST;
			mask_q <= `HPSC_MASK_RST;
		end else begin
			sctl_q <= sctl_d;
			cfg_q  <= cfg_d;
			mask_q <= mask_d;
		end
	end

	// Previous levels for change detection; presence starts as present
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			button_prev_q <= 1'b0;
			fault_prev_q  <= 1'b0;
			latch_prev_q  <= `HPSC_LATCH_RST;
			card_prev_q   <= `HPSC_CARD_RST;
			link_prev_q   <= 1'b0;
		end else begin
			button_prev_q <= button_s;
			fault_prev_q  <= fault_s;
			latch_prev_q  <= latch_s;
			card_prev_q   <= card_s;
			link_prev_q   <= link_active;
		end
	end

	// Outputs held in flops
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			toggle_q <= 1'b0;
			irq_q    <= 1'b0;
		end else begin
			toggle_q <= toggle_d;
			irq_q    <= irq_d;
		end
	end

	assign prdata           = prdata_q;
	assign pready           = pready_q;
	assign pslverr          = pslverr_q;
	assign interlock_toggle = toggle_q;
	assign hotplug_irq      = irq_q;

	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	AST_TOGGLE_READ_ZERO: assert property (
		(done && !pwrite && sel == hpsc_pkg::HPSC_SEL_SCTL) |-> !prdata[`HPSC_SCTL_TOGGLE])
		else $error("Interlock control bit read back as one");

	AST_TOGGLE_PULSE: assert property (
		toggle_d |=> interlock_toggle ##1 !interlock_toggle)
		else $error("Interlock toggle pulse missing or too long");

	AST_TOGGLE_NOCAP: assert property (
		(wr_sctl && !ilock_ok) |=> !interlock_toggle)
		else $error("Interlock toggled without capability");

	AST_LINK_FLAG: assert property (
		link_chg |=> flags[`HPSC_SSTS_LINKCHG])
		else $error("Link change did not set its flag");

	AST_BUTTON_FLAG: assert property (
		(button_s && !button_prev_q) |=> flags[`HPSC_SSTS_BUTTON])
		else $error("Button press did not set its flag");

	AST_FAULT_STICKY: assert property (
		(flags[`HPSC_SSTS_PFAULT] && !ev_clr[`HPSC_SSTS_PFAULT])
		|=> flags[`HPSC_SSTS_PFAULT])
		else $error("Power fault flag dropped without a clear");

	AST_CARD_FLAG: assert property (
		$changed(card_s) |-> flags[`HPSC_SSTS_CARDCHG] ##1 flags[`HPSC_SSTS_CARDCHG]
		or ##1 flags[`HPSC_SSTS_CARDCHG])
		else $error("Presence change did not set its flag");

	AST_IRQ_MASTER: assert property (
		!sctl_q[`HPSC_SCTL_MASTER] |=> !hotplug_irq)
		else $error("Interrupt raised with master enable clear");

	AST_IRQ_RAISE: assert property (
		(sctl_q[`HPSC_SCTL_MASTER] && (|(flags & flag_en & mask_q))) |=> hotplug_irq)
		else $error("Enabled pending event did not raise interrupt");

	AST_RESERVED: assert property (
		(done && !pwrite) |-> (prdata[31:16] == 16'h0000 &&
		(sel != hpsc_pkg::HPSC_SEL_SSTS || prdata[15:9] == 7'h00)))
		else $error("Reserved bits read non-zero");

	// Every event must land in its own flag one edge after it is seen
	AST_FAULT_FLAG: assert property (
		fault_rise
		|=> flags[`HPSC_SSTS_PFAULT])
		else $error("Power fault did not set its flag");

	AST_LATCH_FLAG: assert property (
		latch_chg
		|=> flags[`HPSC_SSTS_LATCHCHG])
		else $error("Latch sensor change did not set its flag");

	AST_CMD_FLAG: assert property (
		cmd_done
		|=> flags[`HPSC_SSTS_CMDDONE])
		else $error("Command completion did not set its flag");

	AST_BUTTON_STICKY: assert property (
		(flags[`HPSC_SSTS_BUTTON] && !ev_clr[`HPSC_SSTS_BUTTON])
		|=> flags[`HPSC_SSTS_BUTTON])
		else $error("Button flag dropped without a clear");

	// A one written with no competing event must clear the flag
	AST_LATCH_CLEAR: assert property (
		(ev_clr[`HPSC_SSTS_LATCHCHG] && !ev_set[`HPSC_SSTS_LATCHCHG])
		|=> !flags[`HPSC_SSTS_LATCHCHG])
		else $error("Latch change flag not cleared by a one");

	AST_CMD_CLEAR: assert property (
		(ev_clr[`HPSC_SSTS_CMDDONE] && !ev_set[`HPSC_SSTS_CMDDONE])
		|=> !flags[`HPSC_SSTS_CMDDONE])
		else $error("Command done flag not cleared by a one");

	AST_LINK_CLEAR: assert property (
		(ev_clr[`HPSC_SSTS_LINKCHG] && !ev_set[`HPSC_SSTS_LINKCHG])
		|=> !flags[`HPSC_SSTS_LINKCHG])
		else $error("Link change flag not cleared by a one");

	// Live state bits must match the levels seen when the read was taken
	AST_LATCH_STATE: assert property (
		(done && !pwrite && sel == hpsc_pkg::HPSC_SEL_SSTS)
		|-> prdata[`HPSC_SSTS_LATCH] == $past(latch_s))
		else $error("Latch state bit differs from the sensor");

	AST_CARD_STATE: assert property (
		(done && !pwrite && sel == hpsc_pkg::HPSC_SEL_SSTS)
		|-> prdata[`HPSC_SSTS_CARD] == $past(card_s))
		else $error("Presence state bit differs from the pin");

	AST_ILOCK_STATE: assert property (
		(done && !pwrite && sel == hpsc_pkg::HPSC_SEL_SSTS)
		|-> prdata[`HPSC_SSTS_ILOCK] == $past(ilock_st))
		else $error("Interlock state bit differs from the pin");

	AST_TOGGLE_ZERO_WRITE: assert property (
		(wr_sctl && !pwdata[`HPSC_SCTL_TOGGLE])
		|=> !interlock_toggle)
		else $error("Zero write to the toggle bit moved the interlock");

	AST_CTRL_RESERVED: assert property (
		(done && !pwrite && sel == hpsc_pkg::HPSC_SEL_SCTL)
		|-> prdata[15:13] == 3'b000)
		else $error("Reserved control bits read non-zero");

	AST_LINK_IRQ: assert property (
		(sctl_q[`HPSC_SCTL_MASTER] && sctl_q[`HPSC_SCTL_DLCE] && mask_q[`HPSC_SSTS_LINKCHG]
		&& flags[`HPSC_SSTS_LINKCHG]) |=> hotplug_irq)
		else $error("Enabled link change did not raise interrupt");

	AST_CARD_IRQ: assert property (
		(sctl_q[`HPSC_SCTL_MASTER] && sctl_q[`HPSC_SSTS_CARDCHG] && mask_q[`HPSC_SSTS_CARDCHG]
		&& flags[`HPSC_SSTS_CARDCHG]) |=> hotplug_irq)
		else $error("Enabled presence change did not raise interrupt");

	AST_IRQ_DROP: assert property (
		!(|(flags & flag_en & mask_q))
		|=> !hotplug_irq)
		else $error("Interrupt held with no enabled event pending");

endmodule

// *** inc/hpsc_map.svh ***
`ifndef HPSC_MAP_SVH
`define HPSC_MAP_SVH

// Register indices; the byte address on the bus is four times the index
`define HPSC_SCTL_IDX        12'h058
`define HPSC_SSTS_IDX        12'h05A
`define HPSC_CFG_IDX         12'h080
`define HPSC_MASK_IDX        12'h081
`define HPSC_SCTL_ADDR       (`HPSC_SCTL_IDX * 12'h004)
`define HPSC_SSTS_ADDR       (`HPSC_SSTS_IDX * 12'h004)
`define HPSC_CFG_ADDR        (`HPSC_CFG_IDX * 12'h004)
`define HPSC_MASK_ADDR       (`HPSC_MASK_IDX * 12'h004)

// Slot control field positions
`define HPSC_SCTL_MASTER     5
`define HPSC_SCTL_TOGGLE     11
`define HPSC_SCTL_DLCE       12
`define HPSC_SCTL_WMASK      16'h103F
`define HPSC_SCTL_RST        16'h0000

// Slot status field positions
`define HPSC_SSTS_BUTTON     0
`define HPSC_SSTS_PFAULT     1
`define HPSC_SSTS_LATCHCHG   2
`define HPSC_SSTS_CARDCHG    3
`define HPSC_SSTS_CMDDONE    4
`define HPSC_SSTS_LATCH      5
`define HPSC_SSTS_CARD       6
`define HPSC_SSTS_ILOCK      7
`define HPSC_SSTS_LINKCHG    8
`define HPSC_SSTS_W1C_MASK   16'h011F
`define HPSC_LATCH_RST       1'b0
`define HPSC_CARD_RST        1'b1

// Configuration and interrupt mask registers
`define HPSC_CFG_ILOCK       0
`define HPSC_CFG_WMASK       16'h0001
`define HPSC_CFG_RST         16'h0000
`define HPSC_MASK_RST        16'h0000

// Pin synchroniser reset image: {interlock, card, latch, fault, button}
`define HPSC_PIN_RST         5'h08

`endif

// *** inc/hpsc_pkg.sv ***
package hpsc_pkg;

	// Register target selected by the current bus address
	typedef enum logic [2:0] {
		HPSC_SEL_NONE,
		HPSC_SEL_SCTL,
		HPSC_SEL_SSTS,
		HPSC_SEL_CFG,
		HPSC_SEL_MASK
	} hpsc_sel_t;

	typedef logic [15:0] hpsc_reg16_t;

endpackage

// *** rtl/hpsc_sync.sv ***
`timescale 1ns/1ps

module hpsc_sync #(
	parameter int          WIDTH  = 5,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	input  logic             clk,     // Core clock
	input  logic             rst_n,   // Async reset, active low
	input  logic [WIDTH-1:0] d,       // Asynchronous pin levels
	output logic [WIDTH-1:0] q        // Synchronised levels
);

	generate
		if (WIDTH < 1) begin : g_chk
			$error("hpsc_sync: WIDTH must be at least one");
		end
	endgenerate

	logic [WIDTH-1:0] meta_q;

	// Two stages; the first one feeds only the second to bound metastability
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= RST_VAL;
			q      <= RST_VAL;
		end else begin
			meta_q <= d;
			q      <= meta_q;
		end
	end

endmodule

// *** rtl/hpsc_evflag.sv ***
`timescale 1ns/1ps

module hpsc_evflag (
	input  logic clk,     // Core clock
	input  logic rst_n,   // Async reset, active low
	input  logic set,     // Event pulse
	input  logic clr,     // Write-one-to-clear strobe
	output logic flag_q   // Sticky flag
);

	logic flag_d;

	// Set beats clear so an event landing on the clear cycle is kept
	assign flag_d = set | (flag_q & ~clr);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			flag_q <= 1'b0;
		end else begin
			flag_q <= flag_d;
		end
	end

endmodule

// *** testbench/hpsc_slot_model.sv ***
`timescale 1ns/1ps

// Behavioural slot side: button, power controller, sensors, interlock, link
module hpsc_slot_model (
	input  logic       pclk,                 // Core clock
	input  logic [5:0] kick,                 // One-cycle event requests from the bench
	input  logic       interlock_toggle,     // Flip request from the block
	output logic       attn_button,          // Button pin
	output logic       power_fault_in,       // Fault pin
	output logic       latch_open_in,        // Latch sensor, high when open
	output logic       card_present_in,      // Presence detect, card in at start
	output logic       interlock_engaged_in, // Interlock feedback
	output logic       link_active,          // Link active level
	output logic       cmd_done,             // Command finished pulse
	output int         flips                 // Interlock flips performed
);
	initial begin
		{attn_button, power_fault_in, latch_open_in} = 3'b000;
		{interlock_engaged_in, link_active, cmd_done} = 3'b000;
		card_present_in = 1'b1;
		flips = 0;
	end

	// Pulses last one cycle, wide enough for the two-flop synchroniser
	always @(posedge pclk) begin
		attn_button <= kick[0];
		power_fault_in <= kick[1];
		latch_open_in <= latch_open_in ^ kick[2];
		card_present_in <= card_present_in ^ kick[3];
		cmd_done <= kick[4];
		link_active <= link_active ^ kick[5];
		if (interlock_toggle === 1'b1) begin
			interlock_engaged_in <= ~interlock_engaged_in;
			flips <= flips + 1;
		end
	end
endmodule

// *** testbench/hotplug_slot_status_control_test.sv ***
`timescale 1ns/1ps
`include "hpsc_map.svh"

module hotplug_slot_status_control_test;
	logic pclk, presetn, psel, penable, pwrite, pslverr, pready;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [5:0]  kick;
	logic a_btn, a_pf, a_lat, a_card, a_il, a_link, a_cmd, tgl, irq;
	logic [32:0] expq[$];
	logic [31:0] x;
	logic [15:0] d, bitv;
	logic        latch_s, card_s, ilock_s;
	int          flips, exp_flips, err_total, n_compared, cyc;

	hpsc_slot_regs uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .attn_button(a_btn), .power_fault_in(a_pf),
		.latch_open_in(a_lat), .card_present_in(a_card), .interlock_engaged_in(a_il),
		.link_active(a_link), .cmd_done(a_cmd), .interlock_toggle(tgl), .hotplug_irq(irq));
	hpsc_slot_model slot (.pclk(pclk), .kick(kick), .interlock_toggle(tgl),
		.attn_button(a_btn), .power_fault_in(a_pf), .latch_open_in(a_lat),
		.card_present_in(a_card), .interlock_engaged_in(a_il), .link_active(a_link),
		.cmd_done(a_cmd), .flips(flips));

	task automatic check(input logic [32:0] seen, input logic [32:0] exp);
		n_compared++;
		if (seen !== exp) begin
			err_total++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic summarize();
		$display("compared %0d mismatches %0d", n_compared, err_total);
		if (err_total == 0 && n_compared > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask

	// One APB transfer; the expected answer is queued for the monitor
	task automatic apb(input logic w, input logic [11:0] a, input logic [15:0] v,
			input logic [32:0] exp);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= {16'h0000, v};
		expq.push_back(exp);
		@(posedge pclk);
		penable <= 1'b1;
		// Wait for the slave as long as it takes; only the bench timeout ends a hang
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [15:0] v);
		apb(1'b1, a, v, {1'b0, 32'h0000_0000});
	endtask

	function automatic logic [32:0] st(input logic [15:0] fl);
		return {17'h0_0000, fl | {8'h00, ilock_s, card_s, latch_s, 5'h00}};
	endfunction

	function automatic logic [31:0] xs(input logic [31:0] v);
		v = v ^ (v << 13);
		v = v ^ (v >> 17);
		return v ^ (v << 5);
	endfunction

	task automatic irq_is(input logic e);
		repeat (3) @(posedge pclk);
		check({32'h0000_0000, irq}, {32'h0000_0000, e});
	endtask

	task automatic fire(input int k);
		kick <= 6'h01 << k;
		@(posedge pclk);
		kick <= 6'h00;
		repeat (6) @(posedge pclk);
	endtask

	// Monitor: every completed transfer is held against the oldest note
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && expq.size() > 0)
			check({pslverr, pwrite ? 32'h0000_0000 : prdata}, expq.pop_front());
	end

	// A hang is cut short well beyond the expected run length
	always @(posedge pclk) begin
		cyc++;
		if (cyc == 20000) begin
			err_total++;
			summarize();
		end
	end

	initial begin
		pclk = 1'b0;
		forever #12.5 pclk = ~pclk;
	end

	initial begin
		{presetn, psel, penable, pwrite} = 4'h0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		kick = 6'h00;
		x = 32'h0000_0d7d;
		{latch_s, card_s, ilock_s} = 3'b010;
		err_total = 0;
		n_compared = 0;
		cyc = 0;
		exp_flips = 0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, `HPSC_SCTL_ADDR, 16'h0000, 33'h0_0000_0000);
		apb(1'b0, `HPSC_SSTS_ADDR, 16'h0000, st(16'h0000));
		apb(1'b0, 12'h010, 16'h0000, 33'h1_0000_0000);
		apb(1'b1, 12'h010, 16'hFFFF, 33'h1_0000_0000);
		// Random control writes, first without interlock, then with it
		for (int c = 0; c < 2; c++) begin
			wr(`HPSC_CFG_ADDR, c[15:0]);
			for (int i = 0; i < 4; i++) begin
				x = xs(x);
				// First write of each pass always asks for a toggle
				d = x[15:0] | ((i == 0) ? 16'h0800 : 16'h0000);
				wr(`HPSC_SCTL_ADDR, d);
				if (c == 1 && d[11]) begin
					exp_flips++;
					ilock_s = ~ilock_s;
				end
				apb(1'b0, `HPSC_SCTL_ADDR, 16'h0000, {17'h0_0000, d & 16'h103F});
			end
			check(flips, exp_flips);
		end
		wr(`HPSC_SCTL_ADDR, 16'h0800);
		wr(`HPSC_SCTL_ADDR, 16'h0000);
		ilock_s = ~ilock_s;
		repeat (4) @(posedge pclk);
		check(flips, exp_flips + 1);
		apb(1'b0, `HPSC_SSTS_ADDR, 16'h0000, st(16'h0000));
		// Each event sets its flag, a zero write keeps it, a one clears it
		for (int k = 0; k < 6; k++) begin
			fire(k);
			latch_s ^= (k == 2);
			card_s ^= (k == 3);
			bitv = (k == 5) ? 16'h0100 : 16'h0001 << k;
			apb(1'b0, `HPSC_SSTS_ADDR, 16'h0000, st(bitv));
			wr(`HPSC_SSTS_ADDR, 16'hFE00 | ~bitv);
			apb(1'b0, `HPSC_SSTS_ADDR, 16'h0000, st(bitv));
			wr(`HPSC_SSTS_ADDR, bitv);
			apb(1'b0, `HPSC_SSTS_ADDR, 16'h0000, st(16'h0000));
		end
		// Interrupt: presence and link enabled, button left disabled
		wr(`HPSC_MASK_ADDR, 16'h011F);
		wr(`HPSC_SCTL_ADDR, 16'h1028);
		fire(0);
		irq_is(1'b0);
		wr(`HPSC_SSTS_ADDR, 16'h0001);
		fire(3);
		card_s ^= 1'b1;
		irq_is(1'b1);
		wr(`HPSC_SCTL_ADDR, 16'h1008);
		irq_is(1'b0);
		wr(`HPSC_SCTL_ADDR, 16'h1028);
		irq_is(1'b1);
		wr(`HPSC_SSTS_ADDR, 16'h0008);
		irq_is(1'b0);
		fire(5);
		irq_is(1'b1);
		wr(`HPSC_SSTS_ADDR, 16'h0100);
		irq_is(1'b0);
		repeat (4) @(posedge pclk);
		summarize();
	end
endmodule
